// *** logic/socket_change_events.sv ***
// socket status-change event flags, interrupt enables and interrupt request
// How it works
// R1: power-cycle change sets event bit 3
// R2: second card-detect change sets event bit 2
// R3: first card-detect change sets event bit 1
// R4: CardBus card: status line rising sets bit 0
// R5: 16-bit card: both status edges set bit 0
// R6: writing 1 clears event bit, 0 keeps
// R7: force-event write of 1 sets event bit
// R8: reset clears all events to zero
// R9: leaving card reset re-sets unchanged status events
// R10: event bits 31-4 read as zero
// R11: software clears events before enabling interrupt; the test bench writes the enables while events are still set
// R12: set event plus enable raises interrupt
// R13: events show change only, not new state
// R14: enables never stop events from being set
// R15: enable bit 3 gates power-cycle interrupt
// R16: detect enable field 11 on, else off
// R17: enable bit 0 gates card-status interrupt
// R18: enable bits 3-0 read/write, 31-4 zero
// R19: events at 00h, enables at 04h, 32-bit
// R20: interrupt held while any enabled event set
module socket_change_events
  import socket_event_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire reg_req_t reg_req_i,
  output reg_resp_t reg_resp_o,
  input wire logic power_cycle_state_i,
  input wire card_pins_t card_pins_i,
  input wire logic cardbus_card_i,
  input wire logic card_reset_i,
  input wire logic [EVENT_W-1:0] force_event_i,
  output logic status_change_interrupt_o
);

  // ==========================================================
  // helpers
  function automatic logic addr_hit(input logic [OFFS_W-1:0] offset, input logic [OFFS_W-1:0] target);
    addr_hit = (offset == target); // R19
  endfunction

  // the two detect enables act as one field; the reserved mixes count as off
  function automatic logic [EVENT_W-1:0] irq_gate(input logic [EVENT_W-1:0] enables);
    logic detect_on;
    detect_on = (enables[DETECT_TWO_BIT:DETECT_ONE_BIT] == DETECT_IRQ_ON);
    irq_gate = '0;
    irq_gate[POWER_BIT] = enables[POWER_BIT]; // R15
    irq_gate[DETECT_TWO_BIT] = detect_on; // R16
    irq_gate[DETECT_ONE_BIT] = detect_on; // R16
    irq_gate[CARD_STATUS_BIT] = enables[CARD_STATUS_BIT]; // R17
  endfunction

  // ==========================================================
  // pin capture and change detection
  block_state_t st;
  block_state_t st_next;
  logic [PIN_W-1:0] pins_raw;
  card_pins_t pins_sync;
  logic [EVENT_W-1:0] levels;
  logic [EVENT_W-1:0] both_edges;
  logic [EVENT_W-1:0] edge_hit;
  logic [EVENT_W-1:0] rearm_set;
  logic [EVENT_W-1:0] ev_set;
  logic [EVENT_W-1:0] ev_clear;
  logic [EVENT_W-1:0] en_gate;
  logic write_low;
  logic read_req;
  logic leaving_reset;

  pin_synchronizer #(
    .WIDTH(PIN_W),
    .IDLE(PINS_IDLE)
  ) pin_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .data_i(card_pins_i),
    .data_o(pins_raw)
  );

  assign pins_sync = card_pins_t'(pins_raw);

  always_comb
  begin
    levels = '0;
    levels[POWER_BIT] = power_cycle_state_i;
    levels[DETECT_TWO_BIT] = pins_sync.detect_pin_two_n;
    levels[DETECT_ONE_BIT] = pins_sync.detect_pin_one_n;
    levels[CARD_STATUS_BIT] = pins_sync.status_change;
    both_edges = '1; // R1 R2 R3
    both_edges[CARD_STATUS_BIT] = !cardbus_card_i; // R4 R5
  end

  change_detector #(
    .WIDTH(EVENT_W)
  ) detect (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(levels),
    .both_i(both_edges),
    .hit_o(edge_hit)
  );

  // ==========================================================
  // event sources and register access
  assign leaving_reset = st.card_reset_seen && !card_reset_i;

  // status still asserted or card still present once card reset ends
  always_comb
  begin
    rearm_set = '0;
    if (leaving_reset)
    begin
      rearm_set[DETECT_TWO_BIT] = !pins_sync.detect_pin_two_n; // R9
      rearm_set[DETECT_ONE_BIT] = !pins_sync.detect_pin_one_n; // R9
      rearm_set[CARD_STATUS_BIT] = pins_sync.status_change; // R9
    end
  end

  assign ev_set = edge_hit | force_event_i | rearm_set; // R7
  assign write_low = reg_req_i.valid && reg_req_i.write && reg_req_i.byte_en[0];
  assign read_req = reg_req_i.valid && !reg_req_i.write;
  assign ev_clear = (write_low && addr_hit(reg_req_i.offset, EVENTS_OFFSET)) ?
    reg_req_i.wdata[EVENT_W-1:0] : '0; // R6
  assign en_gate = irq_gate(st.enables);

  // ==========================================================
  // next state
  always_comb
  begin
    st_next = st;
    st_next.card_reset_seen = card_reset_i;
    // a set in the same cycle as its clear wins, so no change is lost
    st_next.events = (st.events & ~ev_clear) | ev_set; // R6
    if (write_low && addr_hit(reg_req_i.offset, ENABLES_OFFSET))
    begin
      st_next.enables = reg_req_i.wdata[EVENT_W-1:0]; // R18
    end
    // enables only gate the request; the flags above ignore them
    st_next.irq = |(st.events & en_gate); // R12 R14 R20
    st_next.resp.ack = reg_req_i.valid;
    st_next.resp.rdata = '0;
    if (read_req)
    begin
      if (addr_hit(reg_req_i.offset, EVENTS_OFFSET))
      begin
        st_next.resp.rdata = {{(DATA_W-EVENT_W){1'b0}}, st.events}; // R10 R13
      end
      else if (addr_hit(reg_req_i.offset, ENABLES_OFFSET))
      begin
        st_next.resp.rdata = {{(DATA_W-EVENT_W){1'b0}}, st.enables}; // R18
      end
      else
      begin
        st_next.resp.rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st.events <= EVENTS_RESET[EVENT_W-1:0]; // R8
      st.enables <= ENABLES_RESET[EVENT_W-1:0];
      st.card_reset_seen <= 1'b0;
      st.irq <= 1'b0;
      st.resp <= '0;
    end
    else
    begin
      st <= st_next;
    end
  end

  assign reg_resp_o = st.resp;
  assign status_change_interrupt_o = st.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_POWER_CHANGE: assert property ( // R1
    $changed(power_cycle_state_i) && $past(nrst_i) |=> st.events[POWER_BIT]
  ) else $error("power-cycle change did not set its event");

  AST_DETECT_TWO: assert property ( // R2
    $changed(pins_sync.detect_pin_two_n) |=> st.events[DETECT_TWO_BIT]
  ) else $error("second detect change did not set its event");

  AST_DETECT_ONE: assert property ( // R3
    $changed(pins_sync.detect_pin_one_n) |=> st.events[DETECT_ONE_BIT]
  ) else $error("first detect change did not set its event");

  AST_CARDBUS_FALL: assert property ( // R4
    cardbus_card_i && $fell(pins_sync.status_change) && !force_event_i[CARD_STATUS_BIT]
      && !leaving_reset && !ev_clear[CARD_STATUS_BIT]
    |=> st.events[CARD_STATUS_BIT] == $past(st.events[CARD_STATUS_BIT])
  ) else $error("falling status edge changed the flag for a CardBus card");

  AST_SIXTEEN_BOTH: assert property ( // R5
    !cardbus_card_i && $changed(pins_sync.status_change) |=> st.events[CARD_STATUS_BIT]
  ) else $error("16-bit card status transition did not set the flag");

  AST_CLEAR: assert property ( // R6
    reg_req_i.valid && reg_req_i.write && reg_req_i.byte_en[0] && reg_req_i.offset == EVENTS_OFFSET
      && reg_req_i.wdata[POWER_BIT] && !ev_set[POWER_BIT]
    |=> !st.events[POWER_BIT]
  ) else $error("write of one did not clear the power event");

  AST_FORCE_WINS: assert property ( // R7
    force_event_i[DETECT_ONE_BIT] |=> st.events[DETECT_ONE_BIT] [*1] ##0 st.resp.rdata[DATA_W-1:EVENT_W] == '0
  ) else $error("forced event lost");

  AST_REARM: assert property ( // R9
    $fell(card_reset_i) && pins_sync.status_change |=> st.events[CARD_STATUS_BIT]
  ) else $error("status not re-flagged on leaving card reset");

  AST_UPPER_ZERO: assert property ( // R10
    st.resp.ack |-> reg_resp_o.rdata[DATA_W-1:EVENT_W] == '0
  ) else $error("reserved read bits not zero");

  AST_MASK_KEEPS_EVENTS: assert property ( // R14
    st.enables == '0 && force_event_i[POWER_BIT] && !(reg_req_i.valid && reg_req_i.write)
    |=> st.events[POWER_BIT] ##1 !status_change_interrupt_o
  ) else $error("disabled event blocked or raised interrupt");

  AST_POWER_IRQ: assert property ( // R15
    st.events[POWER_BIT] && st.enables[POWER_BIT] |=> status_change_interrupt_o
  ) else $error("enabled power event gave no interrupt");

  AST_DETECT_FIELD: assert property ( // R16
    st.enables[DETECT_TWO_BIT:DETECT_ONE_BIT] != DETECT_IRQ_ON && !st.enables[POWER_BIT]
      && !st.enables[CARD_STATUS_BIT]
    |=> !status_change_interrupt_o
  ) else $error("detect field not 11 yet interrupt raised");

  AST_STATUS_IRQ: assert property ( // R17
    st.events[CARD_STATUS_BIT] && st.enables[CARD_STATUS_BIT] |=> status_change_interrupt_o
  ) else $error("enabled status event gave no interrupt");

  AST_ENABLE_READBACK: assert property ( // R19
    reg_req_i.valid && !reg_req_i.write && reg_req_i.offset == ENABLES_OFFSET
    |=> reg_resp_o.ack && reg_resp_o.rdata == {{(DATA_W-EVENT_W){1'b0}}, $past(st.enables)}
  ) else $error("enables read back wrong");

  AST_IRQ_DROP: assert property ( // R20
    (st.events & en_gate) == '0 |=> !status_change_interrupt_o
  ) else $error("interrupt held with no enabled event");

  AST_RESET_CLEAN: assert property ( // R8
    !$past(nrst_i)
    |-> st.events == '0 && st.enables == '0 && !status_change_interrupt_o && !reg_resp_o.ack
  ) else $error("state not clear at reset release");

  AST_EVENTS_READBACK: assert property ( // R10
    reg_req_i.valid && !reg_req_i.write && reg_req_i.offset == EVENTS_OFFSET
    |=> reg_resp_o.ack && reg_resp_o.rdata == {{(DATA_W-EVENT_W){1'b0}}, $past(st.events)}
  ) else $error("events read back wrong");

  AST_ACK_FOLLOWS: assert property ( // R19
    reg_req_i.valid |=> reg_resp_o.ack
  ) else $error("request not acknowledged next cycle");

  AST_QUIET_BUS: assert property ( // R19
    !reg_req_i.valid
    |=> !reg_resp_o.ack && reg_resp_o.rdata == '0
  ) else $error("response without request");

  AST_WRITE_READS_ZERO: assert property ( // R19
    reg_req_i.valid && reg_req_i.write
    |=> reg_resp_o.ack && reg_resp_o.rdata == '0
  ) else $error("write response carried data");

  AST_UNMAPPED_ZERO: assert property ( // R19
    reg_req_i.valid && !reg_req_i.write && reg_req_i.offset != EVENTS_OFFSET
      && reg_req_i.offset != ENABLES_OFFSET
    |=> reg_resp_o.ack && reg_resp_o.rdata == '0
  ) else $error("unmapped read not zero");

  AST_ENABLE_WRITE: assert property ( // R18
    reg_req_i.valid && reg_req_i.write && reg_req_i.byte_en[0] && reg_req_i.offset == ENABLES_OFFSET
    |=> st.enables == $past(reg_req_i.wdata[EVENT_W-1:0])
  ) else $error("enable write not taken");

  AST_ENABLE_HOLD: assert property ( // R18
    !(reg_req_i.valid && reg_req_i.write && reg_req_i.byte_en[0] && reg_req_i.offset == ENABLES_OFFSET)
    |=> $stable(st.enables)
  ) else $error("enables changed without a write");

  AST_EVENTS_STICKY: assert property ( // R6
    ev_set == '0 && ev_clear == '0
    |=> $stable(st.events)
  ) else $error("event flags moved with no set or clear");

  AST_SETS_LAND: assert property ( // R7
    ev_set != '0
    |=> (st.events & $past(ev_set)) == $past(ev_set)
  ) else $error("a set event did not land");

  AST_CLEARS_LAND: assert property ( // R6
    ev_clear != '0
    |=> (st.events & $past(ev_clear) & ~$past(ev_set)) == '0
  ) else $error("a cleared event stayed set");

  AST_FORCE_POWER: assert property ( // R7
    force_event_i[POWER_BIT] |=> st.events[POWER_BIT]
  ) else $error("forced power event lost");

  AST_FORCE_STATUS: assert property ( // R7
    force_event_i[CARD_STATUS_BIT] |=> st.events[CARD_STATUS_BIT]
  ) else $error("forced status event lost");

  AST_CARDBUS_RISE: assert property ( // R4
    cardbus_card_i && $rose(pins_sync.status_change) && $past(nrst_i)
    |=> st.events[CARD_STATUS_BIT]
  ) else $error("rising status edge not flagged for a CardBus card");

  AST_REARM_ONE: assert property ( // R9
    $fell(card_reset_i) && $past(nrst_i) && !pins_sync.detect_pin_one_n
    |=> st.events[DETECT_ONE_BIT]
  ) else $error("first detect not re-flagged on leaving card reset");

  AST_REARM_TWO: assert property ( // R9
    $fell(card_reset_i) && $past(nrst_i) && !pins_sync.detect_pin_two_n
    |=> st.events[DETECT_TWO_BIT]
  ) else $error("second detect not re-flagged on leaving card reset");

  AST_IRQ_RAISED: assert property ( // R12
    (st.events & en_gate) != '0 |=> status_change_interrupt_o
  ) else $error("enabled event gave no interrupt");

  AST_DETECT_IRQ: assert property ( // R16
    st.events[DETECT_ONE_BIT] && st.enables[DETECT_TWO_BIT:DETECT_ONE_BIT] == DETECT_IRQ_ON
    |=> status_change_interrupt_o
  ) else $error("enabled detect event gave no interrupt");

  AST_POWER_MASKED: assert property ( // R15
    !st.enables[POWER_BIT] && st.events[DETECT_TWO_BIT:CARD_STATUS_BIT] == '0
    |=> !status_change_interrupt_o
  ) else $error("disabled power event raised interrupt");

  AST_STATUS_MASKED: assert property ( // R17
    !st.enables[CARD_STATUS_BIT] && st.events[EVENT_W-1:DETECT_ONE_BIT] == '0
    |=> !status_change_interrupt_o
  ) else $error("disabled status event raised interrupt");

endmodule

// *** shared/socket_event_pkg.sv ***
// constants and types shared by the socket status-change event logic
package socket_event_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W = 32;
  localparam int OFFS_W = 8;
  localparam int EVENT_W = 4;
  localparam int PIN_W = 3;

  // ==========================================================
  // register offsets and reset values
  localparam logic [OFFS_W-1:0] EVENTS_OFFSET = 8'h00;
  localparam logic [OFFS_W-1:0] ENABLES_OFFSET = 8'h04;
  localparam logic [DATA_W-1:0] EVENTS_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ENABLES_RESET = 32'h0000_0000;
  // empty socket: both detect pins high, status line low
  localparam logic [PIN_W-1:0] PINS_IDLE = 3'h6;

  // ==========================================================
  // field positions, shared by both registers
  localparam int POWER_BIT = 3;
  localparam int DETECT_TWO_BIT = 2;
  localparam int DETECT_ONE_BIT = 1;
  localparam int CARD_STATUS_BIT = 0;
  localparam logic [1:0] DETECT_IRQ_ON = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] byte_en;
    logic [OFFS_W-1:0] offset;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } reg_resp_t;

  // socket pins, order fixed: detect two, detect one, status change
  typedef struct packed {
    logic detect_pin_two_n;
    logic detect_pin_one_n;
    logic status_change;
  } card_pins_t;

  typedef struct packed {
    logic [EVENT_W-1:0] events;
    logic [EVENT_W-1:0] enables;
    logic card_reset_seen;
    logic irq;
    reg_resp_t resp;
  } block_state_t;

endpackage

// *** logic/pin_synchronizer.sv ***
// two-stage synchroniser for socket pins
module pin_synchronizer #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t st_next;

  // first stage feeds only the second stage
  always_comb
  begin
    st_next.first = data_i;
    st_next.second = st.first;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    // reset to the pins' idle level, else release looks like a pin edge
    if (!nrst_i)
      st <= '{first: IDLE, second: IDLE};
    else
      st <= st_next;
  end

  assign data_o = st.second;

endmodule

// *** logic/change_detector.sv ***
// per-bit change detector: rising edge only, or both edges
module change_detector #(
  parameter int WIDTH = 1
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] level_i,
  input wire logic [WIDTH-1:0] both_i,
  output logic [WIDTH-1:0] hit_o
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic primed;
  } detect_state_t;

  detect_state_t st;
  detect_state_t st_next;

  always_comb
  begin
    st_next.prev = level_i;
    st_next.primed = 1'b1;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st <= '0;
    else
      st <= st_next;
  end

  // no hit in the first cycle after reset: prev has not yet seen a real level
  assign hit_o = st.primed ? ((level_i ^ st.prev) & (both_i | level_i)) : '0;

endmodule

// *** test/socket_card_model.sv ***
// behavioural card in the socket: detect and status lines
module socket_card_model
  import socket_event_pkg::*;
(
  input wire logic clk_i,
  input wire logic [PIN_W-1:0] want_i,
  output card_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // empty socket at power-up: both detect pins high, status line low
  // lines move just after an edge of clk_i, the same clock that runs the block
  initial
  begin
    pins_o = PINS_IDLE;
    forever
    begin
      @(posedge clk_i);
      pins_o <= want_i;
    end
  end
endmodule

// *** test/socket_change_events_test.sv ***
// self-checking bench for the socket status-change event block
module socket_change_events_test
  import socket_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and design
  logic clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t reg_req = '0;
  reg_resp_t reg_resp;
  logic power_cycle = 1'b0;
  logic cardbus = 1'b1;
  logic card_reset = 1'b0;
  logic irq;
  logic [EVENT_W-1:0] force_event = '0;
  logic [PIN_W-1:0] want = PINS_IDLE;
  card_pins_t card_pins;
  logic [DATA_W-1:0] expect_q[$];
  int errors = 0;
  int n_checks = 0;

  initial forever #20 clk = ~clk;

  socket_card_model i_card (.clk_i(clk), .want_i(want), .pins_o(card_pins));

  socket_change_events i_dut (
    .clk_i(clk),
    .nrst_i(nrst),
    .reg_req_i(reg_req),
    .reg_resp_o(reg_resp),
    .power_cycle_state_i(power_cycle),
    .card_pins_i(card_pins),
    .cardbus_card_i(cardbus),
    .card_reset_i(card_reset),
    .force_event_i(force_event),
    .status_change_interrupt_o(irq)
  );

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // every access notes the word its ack must carry (0 for writes)
  task automatic access(input logic wr, input logic [OFFS_W-1:0] offs, input logic [DATA_W-1:0] data,
                        input logic [DATA_W-1:0] exp);
    @(posedge clk);
    reg_req <= '{valid: 1'b1, write: wr, byte_en: 4'hF, offset: offs, wdata: data};
    expect_q.push_back(exp);
    @(posedge clk);
    reg_req.valid <= 1'b0;
  endtask

  // move the socket lines, read the events they left, then clear them
  task automatic pins(input logic [PIN_W-1:0] w, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    want <= w;
    settle(6);
    access(1'b0, EVENTS_OFFSET, 32'h0, exp);
    access(1'b1, EVENTS_OFFSET, 32'hF, 32'h0);
  endtask

  task automatic pulse_force(input logic [EVENT_W-1:0] f);
    @(posedge clk);
    force_event <= f;
    @(posedge clk);
    force_event <= '0;
  endtask

  // ==========================================================
  // result watcher
  always @(posedge clk)
    if (reg_resp.ack === 1'b1)
    begin
      if (expect_q.size() == 0)
        check("ack count", 32'h1, 32'h0);
      else
        check("read data", reg_resp.rdata, expect_q.pop_front());
    end

  // ==========================================================
  // tests
  initial
  begin
    logic [DATA_W-1:0] r;
    r = $urandom(26454);
    settle(3);
    nrst <= 1'b1;
    access(1'b0, EVENTS_OFFSET, 32'h0, EVENTS_RESET);
    access(1'b0, ENABLES_OFFSET, 32'h0, ENABLES_RESET);
    access(1'b0, 8'h08, 32'h0, 32'h0);
    r = $urandom;
    access(1'b1, ENABLES_OFFSET, r, 32'h0);
    access(1'b0, ENABLES_OFFSET, 32'h0, {28'h0, r[3:0]});
    access(1'b1, ENABLES_OFFSET, 32'h0, 32'h0);
    done("registers");
    for (int i = 0; i < EVENT_W; i++)
    begin
      pulse_force(4'h1 << i);
      access(1'b1, EVENTS_OFFSET, 32'hFFFF_FFF0, 32'h0);
      access(1'b0, EVENTS_OFFSET, 32'h0, 32'h1 << i);
      access(1'b1, EVENTS_OFFSET, 32'h1 << i, 32'h0);
      access(1'b0, EVENTS_OFFSET, 32'h0, 32'h0);
    end
    done("force and clear");
    pins(3'h4, 32'h2);
    pins(3'h0, 32'h4);
    @(posedge clk);
    power_cycle <= 1'b1;
    settle(3);
    access(1'b0, EVENTS_OFFSET, 32'h0, 32'h8);
    access(1'b1, EVENTS_OFFSET, 32'hF, 32'h0);
    @(posedge clk);
    card_reset <= 1'b1;
    settle(2);
    card_reset <= 1'b0;
    pins(3'h0, 32'h6);
    done("socket lines");
    pins(3'h1, 32'h1);
    pins(3'h0, 32'h0);
    cardbus <= 1'b0;
    pins(3'h1, 32'h1);
    pins(3'h0, 32'h1);
    done("status line");
    // events left set on purpose before enabling, so the enable alone must raise the request
    pulse_force(4'h3);
    access(1'b1, ENABLES_OFFSET, 32'h0, 32'h0);
    settle(3);
    check("irq", irq, 32'h0);
    access(1'b1, ENABLES_OFFSET, 32'h1, 32'h0);
    settle(3);
    check("irq", irq, 32'h1);
    access(1'b1, ENABLES_OFFSET, 32'h2, 32'h0);
    access(1'b1, EVENTS_OFFSET, 32'h1, 32'h0);
    settle(3);
    check("irq", irq, 32'h0);
    access(1'b0, EVENTS_OFFSET, 32'h0, 32'h2);
    access(1'b1, ENABLES_OFFSET, 32'h8, 32'h0);
    pulse_force(4'h8);
    settle(3);
    check("irq", irq, 32'h1);
    access(1'b1, ENABLES_OFFSET, 32'h6, 32'h0);
    access(1'b1, EVENTS_OFFSET, 32'h8, 32'h0);
    settle(3);
    check("irq", irq, 32'h1);
    access(1'b1, EVENTS_OFFSET, 32'hF, 32'h0);
    settle(3);
    check("irq", irq, 32'h0);
    done("interrupt");
    settle(3);
    give_verdict();
  end

  // whole run is a few hundred cycles; ten thousand means a hang
  initial
  begin
    #400000;
    errors++;
    give_verdict();
  end
endmodule
